// ==== mux_move_map.svh ====
`ifndef MUX_MOVE_MAP_SVH
`define MUX_MOVE_MAP_SVH

// opcodes of the instruction group handled here
`define OP_SOURCE_FIELD_MOVE 6'h14
`define OP_CARRY_BIT_MUX     6'h1c
`define OP_INV_CARRY_BIT_MUX 6'h1d
`define OP_ZERO_BIT_MUX      6'h1e
`define OP_INV_ZERO_BIT_MUX  6'h1f

// condition field
`define COND_ALWAYS          4'hf

// source field of a destination word
`define SFIELD_MSB           8
`define SFIELD_W             9

// timing
`define EXEC_CLOCKS          4

// port address map
`define ADDR_MEM_LAST        10'h1ff
`define ADDR_CTRL            10'h200
`define ADDR_FLAGS           10'h201
`define ADDR_PC              10'h202
`define ADDR_STATUS          10'h203
`define ADDR_RETIRED         10'h204

// field positions
`define CTRL_RUN_BIT         0
`define CTRL_STEP_BIT        1
`define FLAGS_ZERO_BIT       0
`define FLAGS_CARRY_BIT      1
`define STATUS_BUSY_BIT      0
`define STATUS_UNSUP_BIT     1
`define STATUS_PC_LSB        16

// reset values
`define CTRL_RST             1'h0
`define PC_RST               9'h000
`define ZERO_RST             1'h0
`define CARRY_RST            1'h0
`define RETIRED_RST          32'h0000_0000

`endif

// ==== mux_move_pkg.sv ====
package mux_move_pkg;

   // instruction word, msb first
   typedef struct packed {
      logic [5:0] opcode;
      logic       eff_zero;
      logic       eff_carry;
      logic       eff_result;
      logic       eff_imm;
      logic [3:0] cond;
      logic [8:0] dst;
      logic [8:0] src;
   } instr_t;

   typedef struct packed {
      logic [31:0] result;
      logic        wr_result;
      logic        upd_zero;
      logic        new_zero;
      logic        upd_carry;
      logic        new_carry;
      logic        supported;
   } alu_out_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FETCH = 3'b001,
      ST_OPER  = 3'b010,
      ST_EXEC  = 3'b011,
      ST_WRITE = 3'b100,
      ST_NEXT  = 3'b101
   } seq_state_t;

endpackage

// ==== mux_move_alu.sv ====
`timescale 1ns/1ps
`include "mux_move_map.svh"

module mux_move_alu (
   input  mux_move_pkg::instr_t   i_instr,   // instruction being executed
   input  wire logic [31:0]       i_dst_val, // destination register value
   input  wire logic [31:0]       i_src_val, // operand, register or literal
   input  wire logic              i_zero,    // current zero flag
   input  wire logic              i_carry,   // current carry flag
   output mux_move_pkg::alu_out_t o_res      // result and flag updates
);

   logic        mux_bit;
   logic        is_mux;
   logic        is_move;
   logic [31:0] res;

   always_comb begin
      is_move = i_instr.opcode == `OP_SOURCE_FIELD_MOVE;
      is_mux  = 1'b1;
      mux_bit = 1'b0;
      unique case (i_instr.opcode)
         `OP_CARRY_BIT_MUX:     mux_bit = i_carry;
         `OP_INV_CARRY_BIT_MUX: mux_bit = ~i_carry;
         `OP_INV_ZERO_BIT_MUX:  mux_bit = ~i_zero;
         `OP_ZERO_BIT_MUX:      mux_bit = i_zero;
         default:               is_mux  = 1'b0;
      endcase
      if (is_move) begin
         res = {i_dst_val[31:`SFIELD_MSB+1],
                i_src_val[`SFIELD_MSB:0]};
      end else begin
         res = (i_dst_val & ~i_src_val) |
               ({32{mux_bit}} & i_src_val);
      end
   end

   always_comb begin
      o_res           = '0;
      o_res.result    = res;
      o_res.supported = is_move | is_mux;
      o_res.wr_result = (is_move | is_mux) & i_instr.eff_result;
      o_res.upd_zero  = (is_move | is_mux) & i_instr.eff_zero;
      // move only tests the nine operand bits
      if (is_move) begin
         o_res.new_zero = i_src_val[`SFIELD_MSB:0] == '0;
      end else begin
         o_res.new_zero = res == 32'h0000_0000;
      end
      // carry left alone for the move, mux gives odd parity
      o_res.upd_carry = is_mux & i_instr.eff_carry;
      o_res.new_carry = ^res;
   end

endmodule

// ==== mux_move_core.sv ====
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "mux_move_map.svh"

// Function
// - A move puts the 9-bit operand into bits 8..0 and keeps the rest.
// - The word after a move is fetched before the move writes back.
// - A move with zero effect sets zero when the 9-bit operand is zero.
// - The result is written unless no-result is given; flags may change.
// - Opcode 011100 sets every masked destination bit to the carry flag.
// - Opcode 011101 sets every masked bit to the inverted carry flag.
// - Opcode 011111 sets every masked bit to the inverted zero flag.
// - Opcode 011110 sets every masked destination bit to the zero flag.
// - A mux with zero effect sets zero when the 32-bit result is zero.
// - A mux with carry effect sets carry to odd parity of the result.
// - The operand is the register named by the source field or a literal.
// - A mux decodes opcode, effects, condition and fields in 4 clocks.
// - The move decodes from opcode 010100 and also takes 4 clocks.

module mux_move_core (
   input  wire logic        i_ref_clk, // core clock, 200 MHz
   input  wire logic        i_rst_b,   // async reset, active low
   input  wire logic [9:0]  i_addr,    // port address
   input  wire logic [31:0] i_wr_data, // port write data
   input  wire logic        i_wr_en,   // port write strobe
   input  wire logic        i_rd_en,   // port read strobe
   output logic      [31:0] o_rd_data, // read data, cycle after strobe
   output logic             o_busy,    // sequencer active
   output logic             o_zero,    // zero flag
   output logic             o_carry    // carry flag
);

   ////////////////////////////////////////////////////////////////////
   // declarations

   logic [31:0]              mem_ff [512];
   mux_move_pkg::seq_state_t state_ff;
   mux_move_pkg::seq_state_t nxt_state;
   mux_move_pkg::instr_t     instr_ff;
   mux_move_pkg::instr_t     prefetch_ff;
   mux_move_pkg::alu_out_t   alu_res;
   mux_move_pkg::alu_out_t   res_ff;
   logic [8:0]               pc_ff;
   logic [8:0]               pc_plus;
   logic [31:0]              dst_val_ff;
   logic [31:0]              src_val_ff;
   logic                     zero_ff;
   logic                     carry_ff;
   logic                     run_ff;
   logic                     step_ff;
   logic                     unsup_ff;
   logic [31:0]              retired_ff;
   logic [31:0]              rd_data_ff;
   logic                     exec_ok;
   logic                     mem_hit;
   logic                     wr_ctrl;
   logic                     wr_flags;
   logic                     wr_pc;
   logic                     wr_status;
   logic                     wr_retired;
   logic                     set_unsup;
   logic                     idle;

   ////////////////////////////////////////////////////////////////////
   // port decode
   // 0x000-0x1ff word memory, 0x200 control, 0x201 flags, 0x202 pc,
   // 0x203 status, 0x204 retired count; the rest reads as zero

   always_comb begin
      mem_hit    = i_addr <= `ADDR_MEM_LAST;
      idle       = state_ff == mux_move_pkg::ST_IDLE;
      wr_ctrl    = i_wr_en & (i_addr == `ADDR_CTRL);
      // port writes to flags and pc only land while halted
      wr_flags   = i_wr_en & (i_addr == `ADDR_FLAGS) & idle;
      wr_pc      = i_wr_en & (i_addr == `ADDR_PC) & idle;
      wr_status  = i_wr_en & (i_addr == `ADDR_STATUS);
      wr_retired = i_wr_en & (i_addr == `ADDR_RETIRED);
   end

   // wraps from the last word back to word zero
   always_comb begin
      pc_plus = 9'(pc_ff + 9'h001);
   end

   ////////////////////////////////////////////////////////////////////
   // register memory, no reset: data only
   // port and write-back share one process so the array keeps a
   // single driver

   always_ff @(posedge i_ref_clk) begin
      if (i_wr_en && mem_hit) begin
         mem_ff[i_addr[8:0]] <= i_wr_data;
      end
      // same address: the core write lands last and wins
      if (state_ff == mux_move_pkg::ST_WRITE && exec_ok &&
          res_ff.wr_result) begin
         mem_ff[instr_ff.dst] <= res_ff.result;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // run control

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_ff <= `CTRL_RST;
      end else if (wr_ctrl) begin
         run_ff <= i_wr_data[`CTRL_RUN_BIT];
      end
   end

   // a step written during next survives: the set wins
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         step_ff <= 1'b0;
      end else if (wr_ctrl && i_wr_data[`CTRL_STEP_BIT]) begin
         step_ff <= 1'b1;
      end else if (state_ff == mux_move_pkg::ST_NEXT) begin
         step_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer, four clocks per instruction
   // fetch once on start, then oper, exec, write, next per word; the
   // following word is already held at next, so a run needs no
   // refetch and keeps the four-clock pace

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         mux_move_pkg::ST_IDLE: begin
            if (run_ff || step_ff) begin
               nxt_state = mux_move_pkg::ST_FETCH;
            end
         end
         mux_move_pkg::ST_FETCH: nxt_state = mux_move_pkg::ST_OPER;
         mux_move_pkg::ST_OPER:  nxt_state = mux_move_pkg::ST_EXEC;
         mux_move_pkg::ST_EXEC:  nxt_state = mux_move_pkg::ST_WRITE;
         mux_move_pkg::ST_WRITE: nxt_state = mux_move_pkg::ST_NEXT;
         mux_move_pkg::ST_NEXT: begin
            // a single step ends here, the prefetch is dropped
            if (run_ff && !step_ff) begin
               nxt_state = mux_move_pkg::ST_OPER;
            end else begin
               nxt_state = mux_move_pkg::ST_IDLE;
            end
         end
         default: nxt_state = mux_move_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_ff <= mux_move_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fetch and prefetch

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         instr_ff <= '0;
      end else if (state_ff == mux_move_pkg::ST_FETCH) begin
         instr_ff <= mem_ff[pc_ff];
      end else if (state_ff == mux_move_pkg::ST_NEXT) begin
         instr_ff <= prefetch_ff;
      end
   end

   // next word is read before this one writes back: in a run, a move
   // that patches its direct successor is not seen by it
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prefetch_ff <= '0;
      end else if (state_ff == mux_move_pkg::ST_OPER) begin
         prefetch_ff <= mem_ff[pc_plus];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pc_ff <= `PC_RST;
      end else if (wr_pc) begin
         pc_ff <= i_wr_data[8:0];
      end else if (state_ff == mux_move_pkg::ST_NEXT) begin
         pc_ff <= pc_plus;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // operand read

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dst_val_ff <= '0;
      end else if (state_ff == mux_move_pkg::ST_OPER) begin
         dst_val_ff <= mem_ff[instr_ff.dst];
      end
   end

   // the literal is zero-extended, upper mask bits stay clear
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         src_val_ff <= '0;
      end else if (state_ff == mux_move_pkg::ST_OPER) begin
         if (instr_ff.eff_imm) begin
            src_val_ff <= {23'h000000, instr_ff.src};
         end else begin
            src_val_ff <= mem_ff[instr_ff.src];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // execute

   mux_move_alu u_alu (
      .i_instr   (instr_ff),
      .i_dst_val (dst_val_ff),
      .i_src_val (src_val_ff),
      .i_zero    (zero_ff),
      .i_carry   (carry_ff),
      .o_res     (alu_res)
   );

   // other condition codes are not handled here and skip
   always_comb begin
      exec_ok = instr_ff.cond == `COND_ALWAYS;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         res_ff <= '0;
      end else if (state_ff == mux_move_pkg::ST_EXEC) begin
         res_ff <= alu_res;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flags

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         zero_ff <= `ZERO_RST;
      end else if (wr_flags) begin
         zero_ff <= i_wr_data[`FLAGS_ZERO_BIT];
      end else if (state_ff == mux_move_pkg::ST_WRITE && exec_ok &&
                   res_ff.upd_zero) begin
         zero_ff <= res_ff.new_zero;
      end
   end

   // a move never asks for a carry update
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         carry_ff <= `CARRY_RST;
      end else if (wr_flags) begin
         carry_ff <= i_wr_data[`FLAGS_CARRY_BIT];
      end else if (state_ff == mux_move_pkg::ST_WRITE && exec_ok &&
                   res_ff.upd_carry) begin
         carry_ff <= res_ff.new_carry;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status and counters

   always_comb begin
      set_unsup = state_ff == mux_move_pkg::ST_WRITE && exec_ok &&
                  !res_ff.supported;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         unsup_ff <= 1'b0;
      end else if (set_unsup) begin
         unsup_ff <= 1'b1;
      end else if (wr_status && i_wr_data[`STATUS_UNSUP_BIT]) begin
         unsup_ff <= 1'b0;
      end
   end

   // skipped words count too, they take the same four clocks
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         retired_ff <= `RETIRED_RST;
      end else if (wr_retired) begin
         retired_ff <= `RETIRED_RST;
      end else if (state_ff == mux_move_pkg::ST_WRITE) begin
         retired_ff <= retired_ff + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read port

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_data_ff <= '0;
      end else if (i_rd_en) begin
         rd_data_ff <= '0;
         if (mem_hit) begin
            rd_data_ff <= mem_ff[i_addr[8:0]];
         end else begin
            unique case (i_addr)
               `ADDR_CTRL: begin
                  rd_data_ff[`CTRL_RUN_BIT] <= run_ff;
                  rd_data_ff[`CTRL_STEP_BIT] <= step_ff;
               end
               `ADDR_FLAGS: begin
                  rd_data_ff[`FLAGS_ZERO_BIT] <= zero_ff;
                  rd_data_ff[`FLAGS_CARRY_BIT] <= carry_ff;
               end
               `ADDR_PC: rd_data_ff[8:0] <= pc_ff;
               `ADDR_STATUS: begin
                  rd_data_ff[`STATUS_BUSY_BIT] <= !idle;
                  rd_data_ff[`STATUS_UNSUP_BIT] <= unsup_ff;
                  rd_data_ff[`STATUS_PC_LSB +: 9] <= pc_ff;
               end
               `ADDR_RETIRED: rd_data_ff <= retired_ff;
               default: rd_data_ff <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   always_comb begin
      o_rd_data = rd_data_ff;
      o_busy    = !idle;
      o_zero    = zero_ff;
      o_carry   = carry_ff;
   end

endmodule

// ==== mux_move_core_properties.sv ====
`timescale 1ns/1ps
`include "mux_move_map.svh"

module mux_move_core_chk (
   input wire logic        i_ref_clk, // core clock
   input wire logic        i_rst_b,   // async reset
   input wire logic [9:0]  i_addr,    // port address
   input wire logic [31:0] i_wr_data, // write data
   input wire logic        i_wr_en,   // write strobe
   input wire logic        i_rd_en,   // read strobe
   input wire logic [31:0] o_rd_data, // read data
   input wire logic        o_busy,    // sequencer active
   input wire logic        o_zero,    // zero flag
   input wire logic        o_carry    // carry flag
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);

   property p_busy_min;
      $rose(o_busy) |-> o_busy[*5];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("busy shorter than fetch plus 4 clocks");
   property p_busy_end;
      $fell(o_busy) |-> $past(o_busy, 5);
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("instruction ended early");
   property p_zero_hold;
      !$stable(o_zero) |-> $past(o_busy)
         || $past(i_wr_en && i_addr == `ADDR_FLAGS);
   endproperty
   a_zero_hold: assert property (p_zero_hold)
      else $error("zero flag moved with no cause");
   property p_carry_hold;
      !$stable(o_carry) |-> $past(o_busy)
         || $past(i_wr_en && i_addr == `ADDR_FLAGS);
   endproperty
   a_carry_hold: assert property (p_carry_hold)
      else $error("carry flag moved with no cause");
   property p_step_start;
      i_wr_en && i_addr == `ADDR_CTRL && i_wr_data[`CTRL_STEP_BIT]
         && !o_busy |-> ##[1:3] o_busy;
   endproperty
   a_step_start: assert property (p_step_start)
      else $error("step did not start the sequencer");
   property p_flags_wr;
      i_wr_en && i_addr == `ADDR_FLAGS && !o_busy |=>
         {o_carry, o_zero} == $past(i_wr_data[1:0]);
   endproperty
   a_flags_wr: assert property (p_flags_wr)
      else $error("idle flag write lost");
   property p_rd_hold;
      !i_rd_en |=> $stable(o_rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");
   property p_unmapped;
      i_rd_en && i_addr > `ADDR_RETIRED |=> o_rd_data == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_status_busy;
      i_rd_en && i_addr == `ADDR_STATUS |=>
         o_rd_data[`STATUS_BUSY_BIT] == $past(o_busy);
   endproperty
   a_status_busy: assert property (p_status_busy)
      else $error("status busy bit wrong");
endmodule

bind mux_move_core mux_move_core_chk i_chk (.i_ref_clk(i_ref_clk),
   .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
   .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
   .o_busy(o_busy), .o_zero(o_zero), .o_carry(o_carry));

// ==== tb_mux_move_core.sv ====
`timescale 1ns/1ps
`include "mux_move_map.svh"

module tb_mux_move_core;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_b   = 1'b0;
   logic [9:0]  i_addr    = 10'h000;
   logic [31:0] i_wr_data = 32'h0;
   logic        i_wr_en   = 1'b0;
   logic        i_rd_en   = 1'b0;
   logic [31:0] o_rd_data;
   logic        o_busy;
   logic        o_zero;
   logic        o_carry;
   int          n_mismatch = 0;
   int          cmp_count  = 0;
   logic        m_z;
   logic        m_c;
   logic        m_unsup;
   logic [5:0]  ops [5] = '{`OP_SOURCE_FIELD_MOVE, `OP_CARRY_BIT_MUX,
      `OP_INV_CARRY_BIT_MUX, `OP_ZERO_BIT_MUX, `OP_INV_ZERO_BIT_MUX};

   always #2.5 i_ref_clk = ~i_ref_clk;

   mux_move_core i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_busy(o_busy),
      .o_zero(o_zero), .o_carry(o_carry));

   ////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, exp, input string s);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr_en   <= 1'b1;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr_en <= 1'b0;
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [31:0] m, exp,
                         input string s);
      @(posedge i_ref_clk);
      i_rd_en <= 1'b1;
      i_addr  <= a;
      @(posedge i_ref_clk);
      i_rd_en <= 1'b0;
      #1 chk_word(o_rd_data & m, exp, s);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      while (o_busy !== 1'b0 && n < 40) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      if (n == 40) begin
         n_mismatch++;
         $display("MISMATCH %0t sequencer stuck busy", $time);
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   // reference model: one stepped instruction at 0x100, dest 0x010
   task automatic exec(input mux_move_pkg::instr_t w,
                       input logic [31:0] dv, sv);
      logic [31:0] op;
      logic [31:0] res;
      logic        b;
      logic        ok;
      logic        mv;
      op = w.eff_imm ? {23'h0, w.src} : sv;
      mv = (w.opcode == `OP_SOURCE_FIELD_MOVE);
      ok = w.cond == `COND_ALWAYS && (mv || w.opcode[5:2] == 4'h7);
      m_unsup = m_unsup | (w.cond == `COND_ALWAYS && !mv &&
                           w.opcode[5:2] != 4'h7);
      b = (w.opcode[1] ? m_z : m_c) ^ w.opcode[0];
      res = mv ? {dv[31:9], op[8:0]} : (dv & ~op) | ({32{b}} & op);
      wr(`ADDR_FLAGS, {30'h0, m_c, m_z});
      wr(10'h010, dv);
      wr(10'h011, sv);
      wr(10'h100, w);
      wr(`ADDR_PC, 32'h100);
      wr(`ADDR_CTRL, 32'h2);
      wait_idle();
      if (ok && w.eff_result) dv = res;
      if (ok && w.eff_zero) begin
         m_z = mv ? op[8:0] == 9'h0 : res == 32'h0;
      end
      if (ok && w.eff_carry && !mv) m_c = ^res;
      rd_chk(10'h010, 32'hffff_ffff, dv, "dest");
      rd_chk(`ADDR_FLAGS, 32'h3, {30'h0, m_c, m_z}, "flags");
      chk_word({30'h0, o_carry, o_zero}, {30'h0, m_c, m_z}, "pins");
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      mux_move_pkg::instr_t w;
      logic [31:0]          sv;
      void'($urandom(87));
      repeat (3) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      m_unsup = 1'b0;
      rd_chk(`ADDR_FLAGS, 32'h3, 32'h0, "reset flags");
      wr(10'h3ff, 32'hffff_ffff);
      rd_chk(10'h3ff, 32'hffff_ffff, 32'h0, "unmapped");
      for (int i = 0; i < 40; i++) begin
         w = $urandom;
         w.opcode = ops[i % 5];
         w.cond = (i == 35) ? 4'h0 : `COND_ALWAYS;
         if (i == 36) w.opcode = 6'h00;
         w.dst = 9'h010;
         if (!w.eff_imm) w.src = 9'h011;
         {m_z, m_c} = 2'($urandom);
         sv = (i % 4 == 0) ? 32'h0 : (i % 4 == 1) ? 32'hffff_ffff : $urandom;
         exec(w, $urandom, sv);
      end
      rd_chk(`ADDR_STATUS, 32'h3, {30'h0, m_unsup, 1'b0}, "status");
      // move patches the mask of its direct successor, old word must run
      wr(10'h010, 32'h0);
      wr(10'h100, {`OP_SOURCE_FIELD_MOVE, 4'h3, `COND_ALWAYS,
                   9'h101, 9'h0f0});
      wr(10'h101, {`OP_ZERO_BIT_MUX, 4'h3, `COND_ALWAYS, 9'h010, 9'h00f});
      wr(`ADDR_FLAGS, 32'h1);
      wr(`ADDR_PC, 32'h100);
      wr(`ADDR_CTRL, 32'h1);
      repeat (5) @(posedge i_ref_clk);
      wr(`ADDR_CTRL, 32'h0);
      wait_idle();
      rd_chk(10'h010, 32'hffff_ffff, 32'h0000_000f, "old word");
      rd_chk(10'h101, 32'h1ff, 32'h0f0, "patched");
      // run stopped after the second word, pc on the third
      rd_chk(`ADDR_PC, 32'h1ff, 32'h0000_0102, "pc after stop");
      // 40 stepped words plus the two of the run
      rd_chk(`ADDR_RETIRED, 32'hffff_ffff, 32'h0000_002a, "retired");
      results();
   end

   initial begin
      #100000;
      n_mismatch++;
      results();
   end
endmodule
